// ---- inc/dmam_pkg.sv ----
// Package for the default memory attribute map and access ordering block
package dmam_pkg;

    // ********************************************************
    // Region boundaries (bases and the last private bus address)
    // ********************************************************
    localparam logic [31:0] DMAM_SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] DMAM_PERIPH_BASE = 32'h4000_0000;
    localparam logic [31:0] DMAM_EXTRAM_BASE = 32'h6000_0000;
    localparam logic [31:0] DMAM_EXTDEV_BASE = 32'hA000_0000;
    localparam logic [31:0] DMAM_PPB_BASE = 32'hE000_0000;
    localparam logic [31:0] DMAM_PPB_LAST = 32'hE00F_FFFF;

    // Reset value of the outstanding transaction count
    localparam logic [3:0] DMAM_OUTST_RESET = 4'h0;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0]
    {
        DMAM_MT_NONE = 2'h0,
        DMAM_MT_NORMAL = 2'h1,
        DMAM_MT_DEVICE = 2'h2,
        DMAM_MT_STRONG = 2'h3
    } dmam_mtype_t;

    typedef enum logic [2:0]
    {
        DMAM_RG_CODE = 3'h0,
        DMAM_RG_SRAM = 3'h1,
        DMAM_RG_PERIPH = 3'h2,
        DMAM_RG_EXTRAM = 3'h3,
        DMAM_RG_EXTDEV = 3'h4,
        DMAM_RG_PPB = 3'h5,
        DMAM_RG_RSVD = 3'h6
    } dmam_region_t;

    // Attributes of one address
    typedef struct packed
    {
        dmam_region_t region;
        dmam_mtype_t mtype;
        logic never_execute_attribute;
        logic bus_fault;
    } dmam_attr_t;

    // Override from the protection unit
    typedef struct packed
    {
        logic hit;
        dmam_mtype_t mtype;
        logic never_execute_attribute;
    } dmam_pu_t;

    // Barrier request kinds
    typedef struct packed
    {
        logic data_memory_barrier;
        logic data_sync_barrier;
        logic instruction_sync_barrier;
    } dmam_barrier_t;

    // Barrier engine states, one-hot
    typedef enum logic [3:0]
    {
        DMAM_ST_IDLE = 4'b0001,
        DMAM_ST_DMB = 4'b0010,
        DMAM_ST_DSB = 4'b0100,
        DMAM_ST_ISB = 4'b1000
    } dmam_state_t;

endpackage

// ---- verilog/dmam_map.sv ----
// Default memory attribute map with barrier and ordering control
// How it works
// - Below 0x2000_0000 is Code: Normal memory, executable.
// - 0x2000_0000 to 0x3FFF_FFFF is SRAM: Normal, executable.
// - 0x4000_0000 to 0x5FFF_FFFF is Peripheral: Device, never-execute.
// - 0x6000_0000 to 0x9FFF_FFFF is external RAM: Normal, executable.
// - 0xA000_0000 to 0xDFFF_FFFF is external device: Device, never-execute.
// - 0xE000_0000 to 0xE00F_FFFF is private bus: Strongly Ordered, never-execute.
// - Fetch from never-execute is blocked; fault only when that instruction executes.
// - Two Device or Strongly Ordered accesses are observed in program order.
// - Device writes may be buffered; Strongly Ordered writes never are.
// - Protection unit region settings override the default type and never-execute, except at reserved addresses.
// - Instructions are prefetched, including speculative branch target fetches.
// - Accesses may be reordered only without changing observable behaviour.
// - Accesses may be buffered or speculative across several buses.
// - Data memory barrier holds later transactions until outstanding ones complete.
// - Data sync barrier holds later instructions until outstanding ones complete.
// - Instruction sync barrier flushes prefetched state.
// - Vector update then data memory barrier: the new vector is fetched.
// - Priority change then data sync barrier: applies when barrier completes.
// - Instruction memory change then instruction sync barrier: new code runs.
// - Memory map switch then data sync barrier: new map used afterwards.
// - Strongly Ordered accesses stay ordered without a data memory barrier.
`timescale 1ns/1ps

module dmam_map
    import dmam_pkg::*;
#(
    parameter int OUTST_W = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Protection unit overrides
    input wire dmam_pu_t pu_fetch,
    input wire dmam_pu_t pu_data,
    // Instruction fetch request from the core
    input wire logic fetch_req,
    input wire logic fetch_speculative,
    input wire logic [31:0] fetch_addr,
    output logic fetch_grant,
    output logic fetch_blocked,
    output dmam_attr_t fetch_attr_q,
    // Execute stage report of a fetched instruction
    input wire logic exec_valid,
    input wire logic exec_from_blocked,
    output logic exec_fault_q,
    // Data request from the core
    input wire logic data_req,
    input wire logic data_write,
    input wire logic [31:0] data_addr,
    output logic data_grant,
    output dmam_attr_t data_attr_q,
    output logic data_bufferable_q,
    output logic data_fault_q,
    // Completion of issued transactions from the slaves
    input wire logic txn_done,
    // Barrier requests and status
    input wire dmam_barrier_t barrier_req,
    output logic barrier_busy,
    output logic exec_hold,
    output logic prefetch_flush_q,
    output logic barrier_done_q
);

    // Refuse counter widths that the full check and reset value cannot serve
    if (OUTST_W < 2 || OUTST_W > 4)
    begin : g_bad_width
        $error("OUTST_W must be 2 to 4");
    end

    // ********************************************************
    // Address decode
    // ********************************************************

    // Fixed map decode, then protection unit override
    function automatic dmam_attr_t decode(input logic [31:0] a, input dmam_pu_t pu);
        dmam_attr_t r;
        r.bus_fault = 1'b0;
        if (a < DMAM_SRAM_BASE)
        begin
            r.region = DMAM_RG_CODE;
            r.mtype = DMAM_MT_NORMAL;
            r.never_execute_attribute = 1'b0;
        end
        else if (a < DMAM_PERIPH_BASE)
        begin
            r.region = DMAM_RG_SRAM;
            r.mtype = DMAM_MT_NORMAL;
            r.never_execute_attribute = 1'b0;
        end
        else if (a < DMAM_EXTRAM_BASE)
        begin
            r.region = DMAM_RG_PERIPH;
            r.mtype = DMAM_MT_DEVICE;
            r.never_execute_attribute = 1'b1;
        end
        else if (a < DMAM_EXTDEV_BASE)
        begin
            r.region = DMAM_RG_EXTRAM;
            r.mtype = DMAM_MT_NORMAL;
            r.never_execute_attribute = 1'b0;
        end
        else if (a < DMAM_PPB_BASE)
        begin
            r.region = DMAM_RG_EXTDEV;
            r.mtype = DMAM_MT_DEVICE;
            r.never_execute_attribute = 1'b1;
        end
        else if (a <= DMAM_PPB_LAST)
        begin
            r.region = DMAM_RG_PPB;
            r.mtype = DMAM_MT_STRONG;
            r.never_execute_attribute = 1'b1;
        end
        else
        begin
            r.region = DMAM_RG_RSVD;
            r.mtype = DMAM_MT_NONE;
            r.never_execute_attribute = 1'b1;
            r.bus_fault = 1'b1;
        end
        if (pu.hit && !r.bus_fault)
        begin
            r.mtype = pu.mtype;
            r.never_execute_attribute = pu.never_execute_attribute;
        end
        return r;
    endfunction

    dmam_attr_t fetch_attr;
    dmam_attr_t data_attr;
    assign fetch_attr = decode(fetch_addr, pu_fetch);
    assign data_attr = decode(data_addr, pu_data);

    // ********************************************************
    // Barrier engine
    // ********************************************************

    dmam_state_t state_q;
    dmam_state_t state_d;
    logic [OUTST_W-1:0] outst_q;
    logic ordered_q;
    logic drained;
    logic issue_data;
    logic ordered_access;

    assign drained = (outst_q == '0);
    assign ordered_access = (data_attr.mtype == DMAM_MT_DEVICE) ||
                            (data_attr.mtype == DMAM_MT_STRONG);

    // Next state of the barrier engine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            DMAM_ST_IDLE:
            begin
                if (barrier_req.data_sync_barrier)
                begin
                    state_d = DMAM_ST_DSB;
                end
                else if (barrier_req.data_memory_barrier)
                begin
                    state_d = DMAM_ST_DMB;
                end
                else if (barrier_req.instruction_sync_barrier)
                begin
                    state_d = DMAM_ST_ISB;
                end
            end
            DMAM_ST_DMB:
            begin
                if (drained)
                begin
                    state_d = DMAM_ST_IDLE;
                end
            end
            DMAM_ST_DSB:
            begin
                if (drained)
                begin
                    state_d = DMAM_ST_IDLE;
                end
            end
            // Flush takes one cycle
            DMAM_ST_ISB:
            begin
                state_d = DMAM_ST_IDLE;
            end
            default:
            begin
                state_d = DMAM_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= DMAM_ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // no data issue during memory barrier
    assign barrier_busy = (state_q != DMAM_ST_IDLE);
    assign exec_hold = (state_q == DMAM_ST_DSB);

    // ordered access waits for earlier ordered one
    assign data_grant = data_req && !barrier_busy &&
                        !(ordered_access && ordered_q && !drained) &&
                        (outst_q != {OUTST_W{1'b1}});
    assign issue_data = data_grant && !data_attr.bus_fault;

    // Outstanding count; a completion in the issue cycle keeps it level
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            outst_q <= OUTST_W'(DMAM_OUTST_RESET);
        end
        else if (issue_data && !(txn_done && !drained))
        begin
            outst_q <= outst_q + OUTST_W'(1);
        end
        else if (!issue_data && txn_done && !drained)
        begin
            outst_q <= outst_q - OUTST_W'(1);
        end
    end

    // normal accesses may overlap; track ordered ones in flight
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ordered_q <= 1'b0;
        end
        else if (issue_data)
        begin
            // A normal access must not hide an ordered one still in flight
            ordered_q <= ordered_access || (ordered_q && !drained);
        end
        else if (drained)
        begin
            ordered_q <= 1'b0;
        end
    end

    // Data attribute and fault outputs
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            data_attr_q <= '0;
            data_bufferable_q <= 1'b0;
            data_fault_q <= 1'b0;
        end
        else
        begin
            data_attr_q <= data_attr;
            data_bufferable_q <= data_grant && data_write &&
                                 (data_attr.mtype == DMAM_MT_DEVICE);
            data_fault_q <= data_grant && data_attr.bus_fault;
        end
    end

    // ********************************************************
    // Fetch path
    // ********************************************************

    // never-execute fetch never reaches the bus
    assign fetch_blocked = fetch_req && fetch_attr.never_execute_attribute;
    assign fetch_grant = fetch_req && !fetch_blocked && !exec_hold &&
                         !(fetch_speculative && state_q == DMAM_ST_ISB);

    // Fetch attributes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fetch_attr_q <= '0;
        end
        else
        begin
            fetch_attr_q <= fetch_attr;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            exec_fault_q <= 1'b0;
        end
        else
        begin
            exec_fault_q <= exec_valid && exec_from_blocked && !exec_hold;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prefetch_flush_q <= 1'b0;
        end
        else
        begin
            prefetch_flush_q <= (state_q == DMAM_ST_ISB);
        end
    end

    // completion marks when new settings apply
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            barrier_done_q <= 1'b0;
        end
        else
        begin
            barrier_done_q <= barrier_busy && (state_d == DMAM_ST_IDLE);
        end
    end

endmodule

// ---- tb/dmam_map_properties.sv ----
// Checker of the attribute map and barrier engine ports
`timescale 1ns/1ps

module dmam_map_properties
    import dmam_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fetch side
    input wire dmam_pu_t pu_fetch,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_grant,
    input wire logic fetch_blocked,
    input wire logic exec_valid,
    input wire logic exec_from_blocked,
    input wire logic exec_fault_q,
    // Data side
    input wire dmam_pu_t pu_data,
    input wire logic data_grant,
    input wire logic data_write,
    input wire logic [31:0] data_addr,
    input wire dmam_attr_t data_attr_q,
    input wire logic data_bufferable_q,
    input wire logic data_fault_q,
    // Barrier status
    input wire logic barrier_busy,
    input wire logic exec_hold,
    input wire logic barrier_done_q,
    input wire logic prefetch_flush_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ****************
    // Assertions
    // ****************
    a_code_normal: assert property (data_addr < DMAM_SRAM_BASE && !pu_data.hit |=>
        data_attr_q.mtype == DMAM_MT_NORMAL && !data_attr_q.never_execute_attribute)
        else $error("code address not normal executable");
    a_ppb_strong: assert property (data_addr >= DMAM_PPB_BASE && data_addr <= DMAM_PPB_LAST
        && !pu_data.hit |=> data_attr_q.mtype == DMAM_MT_STRONG)
        else $error("private bus address not strongly ordered");
    a_rsvd_fault: assert property (data_grant && data_addr > DMAM_PPB_LAST |=> data_fault_q)
        else $error("reserved access without fault");
    a_fetch_nx_block: assert property (fetch_req && !pu_fetch.hit
        && fetch_addr >= DMAM_PERIPH_BASE && fetch_addr < DMAM_EXTRAM_BASE
        |-> fetch_blocked && !fetch_grant) else $error("fetch from never-execute granted");
    a_exec_fault: assert property (exec_valid && exec_from_blocked && !exec_hold
        |=> exec_fault_q) else $error("blocked instruction executed without fault");
    a_strong_unbuf: assert property (data_grant && data_write && !pu_data.hit
        && data_addr >= DMAM_PPB_BASE && data_addr <= DMAM_PPB_LAST |=> !data_bufferable_q)
        else $error("strongly ordered write buffered");
    a_pu_override: assert property (pu_data.hit && data_addr <= DMAM_PPB_LAST
        |=> data_attr_q.mtype == $past(pu_data.mtype)) else $error("override not applied");
    a_busy_no_data: assert property (barrier_busy |-> !data_grant)
        else $error("data granted during barrier");
    a_dsb_hold: assert property (exec_hold |-> barrier_busy && !fetch_grant)
        else $error("fetch granted during sync barrier");

    // Main scenarios reached
    c_done: cover property (barrier_done_q);
    c_flush: cover property (prefetch_flush_q);
    c_fault: cover property (data_fault_q);
endmodule

bind dmam_map dmam_map_properties i_dmam_map_properties (.*);

// ---- tb/dmam_slave_model.sv ----
// Memory side model completing granted data transactions after a latency
`timescale 1ns/1ps

module dmam_slave_model
#(
    parameter int LAT = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Observed data side
    input wire logic data_req,
    input wire logic data_grant,
    input wire logic data_fault_q,
    // Completion pulse
    output logic txn_done
);
    int pend;
    int tmr;
    logic fire;

    assign fire = (pend > 0) && (tmr == LAT - 1);

    // Reserved accesses are dropped: the block faults them and never counts them
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pend <= 0;
            tmr <= 0;
            txn_done <= 1'b0;
        end
        else
        begin
            txn_done <= fire;
            pend <= pend + int'(data_req && data_grant) - int'(data_fault_q) - int'(fire);
            tmr <= (pend > 0 && !fire) ? tmr + 1 : 0;
        end
    end
endmodule

// ---- tb/tb_dmam_map.sv ----
// Testbench of the default memory attribute map
`timescale 1ns/1ps

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module tb_dmam_map
    import dmam_pkg::*;
;
    logic clk, reset, fetch_req, fetch_speculative, exec_valid, exec_from_blocked;
    logic data_req, data_write, txn_done, fetch_grant, fetch_blocked, exec_fault_q;
    logic data_grant, data_bufferable_q, data_fault_q, barrier_busy, exec_hold;
    logic prefetch_flush_q, barrier_done_q;
    logic [31:0] fetch_addr, data_addr;
    dmam_pu_t pu_fetch, pu_data;
    dmam_barrier_t barrier_req;
    dmam_attr_t fetch_attr_q, data_attr_q;
    int error_cnt, tests_run, wt;
    logic [31:0] ta [9] = '{32'h0000_0000, 32'h1FFF_FFFC, 32'h2000_0000, 32'h5FFF_FFFC,
        32'h6000_0000, 32'hA000_0000, 32'hDFFF_FFFC, 32'hE00F_FFFC, 32'hE010_0000};
    dmam_region_t tr [9] = '{DMAM_RG_CODE, DMAM_RG_CODE, DMAM_RG_SRAM, DMAM_RG_PERIPH,
        DMAM_RG_EXTRAM, DMAM_RG_EXTDEV, DMAM_RG_EXTDEV, DMAM_RG_PPB, DMAM_RG_RSVD};
    dmam_mtype_t tm [9] = '{DMAM_MT_NORMAL, DMAM_MT_NORMAL, DMAM_MT_NORMAL, DMAM_MT_DEVICE,
        DMAM_MT_NORMAL, DMAM_MT_DEVICE, DMAM_MT_DEVICE, DMAM_MT_STRONG, DMAM_MT_NONE};
    logic tx [9] = '{0, 0, 0, 1, 0, 1, 1, 1, 1};

    dmam_map i_dmam_map (.clk(clk), .reset(reset), .pu_fetch(pu_fetch), .pu_data(pu_data),
        .fetch_req(fetch_req), .fetch_speculative(fetch_speculative), .fetch_addr(fetch_addr),
        .fetch_grant(fetch_grant), .fetch_blocked(fetch_blocked), .fetch_attr_q(fetch_attr_q),
        .exec_valid(exec_valid), .exec_from_blocked(exec_from_blocked),
        .exec_fault_q(exec_fault_q), .data_req(data_req), .data_write(data_write),
        .data_addr(data_addr), .data_grant(data_grant), .data_attr_q(data_attr_q),
        .data_bufferable_q(data_bufferable_q), .data_fault_q(data_fault_q),
        .txn_done(txn_done), .barrier_req(barrier_req), .barrier_busy(barrier_busy),
        .exec_hold(exec_hold), .prefetch_flush_q(prefetch_flush_q),
        .barrier_done_q(barrier_done_q));

    dmam_slave_model i_dmam_slave_model (.clk(clk), .reset(reset), .data_req(data_req),
        .data_grant(data_grant), .data_fault_q(data_fault_q), .txn_done(txn_done));

    // ****************
    // Shared tasks
    // ****************
    // Holds the request until grant is seen, then releases at the taking edge
    task automatic drv_data(input logic [31:0] a, input logic w);
        @(posedge clk);
        data_req <= 1'b1;
        data_addr <= a;
        data_write <= w;
        wt = 0;
        @(negedge clk);
        while (data_grant !== 1'b1 && wt < 50)
        begin
            wt++;
            @(negedge clk);
        end
        @(posedge clk);
        data_req <= 1'b0;
        #1;
    endtask

    // Barrier of one kind after a normal write, waiting for its done pulse
    task automatic t_barrier(input dmam_barrier_t k);
        int n;
        drv_data(32'h2000_0000, 1'b1);
        barrier_req <= k;
        fetch_req <= 1'b1;
        fetch_speculative <= k.instruction_sync_barrier;
        fetch_addr <= 32'h0000_0100;
        @(posedge clk);
        barrier_req <= '0;
        #1;
        `CHK(barrier_busy, 1'b1)
        `CHK(exec_hold, k.data_sync_barrier)
        `CHK(fetch_grant, !k.data_sync_barrier & !k.instruction_sync_barrier)
        n = 0;
        while (barrier_done_q !== 1'b1 && n < 20)
        begin
            `CHK(prefetch_flush_q, 1'b0)
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(barrier_done_q, 1'b1)
        `CHK(prefetch_flush_q, k.instruction_sync_barrier)
        `CHK(n > 2, k.instruction_sync_barrier == 0)
        fetch_req <= 1'b0;
        fetch_speculative <= 1'b0;
        $display("barrier test done");
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_regions();
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            fetch_req <= 1'b1;
            fetch_addr <= ta[i];
            data_addr <= ta[i];
            @(posedge clk);
            #1;
            `CHK(data_attr_q.region, tr[i])
            `CHK(data_attr_q.mtype, tm[i])
            `CHK(fetch_blocked, tx[i])
            `CHK(fetch_attr_q.never_execute_attribute, tx[i])
            `CHK(fetch_grant, !tx[i])
        end
        fetch_req <= 1'b0;
        $display("region test done");
    endtask

    task automatic t_override();
        @(posedge clk);
        pu_data <= '{1'b1, DMAM_MT_DEVICE, 1'b1};
        pu_fetch <= '{1'b1, DMAM_MT_NORMAL, 1'b0};
        data_addr <= 32'h0000_0100;
        fetch_addr <= 32'h4000_0000;
        fetch_req <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(data_attr_q.mtype, DMAM_MT_DEVICE)
        `CHK(fetch_blocked, 1'b0)
        pu_data <= '0;
        pu_fetch <= '0;
        fetch_req <= 1'b0;
        $display("override test done");
    endtask

    task automatic t_order();
        drv_data(32'h4000_0000, 1'b1);
        `CHK(data_bufferable_q, 1'b1)
        drv_data(32'hE000_0E00, 1'b1);
        `CHK(wt > 0, 1'b1)
        `CHK(data_bufferable_q, 1'b0)
        drv_data(32'hE010_0000, 1'b0);
        `CHK(data_fault_q, 1'b1)
        // Device, normal, device: the last must still wait for the first
        drv_data(32'h4000_0000, 1'b1);
        drv_data(32'h2000_0000, 1'b1);
        drv_data(32'h4000_0004, 1'b0);
        `CHK(wt > 0, 1'b1)
        $display("order test done");
    endtask

    task automatic t_exec();
        @(posedge clk);
        exec_valid <= 1'b1;
        exec_from_blocked <= 1'b1;
        @(posedge clk);
        exec_from_blocked <= 1'b0;
        #1;
        `CHK(exec_fault_q, 1'b1)
        @(posedge clk);
        exec_valid <= 1'b0;
        #1;
        `CHK(exec_fault_q, 1'b0)
        $display("exec test done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Free running clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Watchdog sized well above the expected run
    initial
    begin
        #(20 * 5000);
        error_cnt++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        {reset, fetch_req, fetch_speculative, exec_valid, exec_from_blocked} = 5'b1_0000;
        {data_req, data_write, fetch_addr, data_addr} = '0;
        {pu_fetch, pu_data, barrier_req} = '0;
        error_cnt = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_regions();
        t_override();
        t_order();
        t_exec();
        t_barrier('{1'b1, 1'b0, 1'b0});
        t_barrier('{1'b0, 1'b1, 1'b0});
        t_barrier('{1'b0, 1'b0, 1'b1});
        give_verdict();
    end
endmodule
